/* File: rtl/bcac_consts.svh */
`ifndef BCAC_CONSTS_SVH
`define BCAC_CONSTS_SVH

// Register indices; the byte address is four times the index
`define BCAC_CON0_IDX 10'h040
`define BCAC_CON1_IDX 10'h042
`define BCAC_FWM_IDX 10'h044
`define BCAC_LWM_IDX 10'h046
`define BCAC_DPTR_IDX 10'h048
`define BCAC_SIZE_IDX 10'h04A
`define BCAC_STAT_IDX 10'h04C

// Reset values
`define BCAC_CON_RST 16'h0000
`define BCAC_MASK_RST 16'hFFFF

// Control word zero fields
`define BCAC_ASH_HI 15
`define BCAC_ASH_LO 12
`define BCAC_SOURCE_A_ENABLE_BIT 11
`define BCAC_SOURCE_B_ENABLE_BIT 10
`define BCAC_SOURCE_C_ENABLE_BIT 9
`define BCAC_USED_BIT 8
`define BCAC_LF_HI 7
`define BCAC_LF_LO 0

// Control word one fields
`define BCAC_BSH_HI 15
`define BCAC_BSH_LO 12
`define BCAC_EFE_BIT 4
`define BCAC_IFE_BIT 3
`define BCAC_FCI_BIT 2
`define BCAC_DESCENDING_ADDRESSING_BIT 1
`define BCAC_LINE_BIT 0

// Size register fields and address step in bytes per word
`define BCAC_SZ_H_HI 15
`define BCAC_SZ_H_LO 8
`define BCAC_SZ_W_HI 7
`define BCAC_SZ_W_LO 0
`define BCAC_ADDR_STEP 24'h000002

// Default FIFO depth in words
`define BCAC_FIFO_DEPTH 32

`endif

/* File: rtl/bcac_pkg.sv */
package bcac_pkg;

  typedef logic [15:0] bcac_word_t;
  typedef logic [23:0] bcac_addr_t;

  typedef enum logic [0:0] {
    BCAC_IDLE,
    BCAC_RUN
  } bcac_state_e;

  typedef struct packed {
    bcac_word_t con0;
    bcac_word_t con1;
    bcac_word_t fwm;
    bcac_word_t lwm;
    bcac_addr_t dptr;
    logic [7:0] width;
    logic [7:0] height;
    bcac_state_e st;
    logic [7:0] col;
    logic [7:0] row;
    bcac_addr_t addr;
    bcac_word_t prev_a;
    bcac_word_t prev_b;
    logic carry;
    logic line_err;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic src_ready;
    logic out_valid;
    bcac_word_t out_data;
    bcac_addr_t out_addr;
  } bcac_state_s;

endpackage

/* File: rtl/bcac_fifo.sv */
`timescale 1ns/100ps

// Synchronous FIFO; count is exact so the caller can throttle early
module bcac_fifo #(
  parameter int WIDTH = 40,
  parameter int DEPTH = 32,
  parameter int CW = $clog2(DEPTH + 1)
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [CW-1:0] count
);
  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [CW-1:0] cnt;
  } bcac_fifo_s;

  bcac_fifo_s f_r;
  bcac_fifo_s f_nxt;
  logic push;
  logic pop;

  // Pointer wrap relies on a power of two depth
  if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_chk
    $error("bcac_fifo: DEPTH must be a power of two, at least 2");
  end

  assign in_ready = (f_r.cnt != CW'(DEPTH));
  assign out_valid = (f_r.cnt != '0);
  assign out_data = f_r.mem[f_r.rp];
  assign count = f_r.cnt;
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Next state of pointers, count and storage
  always_comb begin
    f_nxt = f_r;
    if (push) begin
      f_nxt.mem[f_r.wp] = in_data;
      f_nxt.wp = f_r.wp + 1'b1;
    end
    if (pop) begin
      f_nxt.rp = f_r.rp + 1'b1;
    end
    f_nxt.cnt = f_r.cnt + CW'(push) - CW'(pop);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      f_r <= '0;
    end else begin
      f_r <= f_nxt;
    end
  end
endmodule

/* File: rtl/bcac_logic_unit.sv */
`timescale 1ns/100ps

// Per-bit minterm selection followed by the area fill carry chain
module bcac_logic_unit
  import bcac_pkg::*;
(
  input wire bcac_word_t a_word,
  input wire bcac_word_t b_word,
  input wire bcac_word_t c_word,
  input wire logic [7:0] minterm_select,
  input wire logic exclusive_fill_on,
  input wire logic inclusive_fill_on,
  input wire logic carry_in,
  output bcac_word_t mt_word,
  output bcac_word_t d_word,
  output logic carry_out
);
  logic [16:0] chain;
  logic fill_on;

  assign fill_on = exclusive_fill_on | inclusive_fill_on;
  assign chain[0] = carry_in;

  // Fill walks from bit 0 upward; exclusive wins if both are set
  for (genvar i = 0; i < 16; i++) begin : g_bit
    assign mt_word[i] = minterm_select[{a_word[i], b_word[i], c_word[i]}];
    assign chain[i+1] = chain[i] ^ mt_word[i];
    assign d_word[i] = exclusive_fill_on ? chain[i+1] :
                       inclusive_fill_on ? (mt_word[i] | chain[i]) :
                       mt_word[i];
  end

  // Without fill the line carry stays parked at its start value
  assign carry_out = fill_on ? chain[16] : carry_in;
endmodule

/* File: rtl/bcac_top.sv */
`timescale 1ns/100ps
`include "bcac_consts.svh"

// Behaviour
// - Source A's first word of each line is ANDed with the first-word mask and its last word with the last-word mask.
// - A zero mask bit forces the matching source A bit to zero whatever was fetched.
// - Bit 0 of control word one picks the mode, zero meaning area mode.
// - Bits 11..8 of word zero enable channels A, B, C and D; a disabled channel moves no data.
// - Each result bit is the minterm enable picked by the A, B, C bits, from bits 7..0 of word zero.
// - Bit 4 of word one turns on exclusive fill of the result in area mode.
// - Bit 3 of word one turns on inclusive fill of the result in area mode.
// - Bit 2 of word one is the fill carry loaded at the start of every line.
// - Bit 1 of word one makes addresses step downward instead of upward.
module bcac_top
  import bcac_pkg::*;
#(
  parameter int FIFO_DEPTH = `BCAC_FIFO_DEPTH
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire bcac_word_t src_a_data,
  input wire bcac_word_t src_b_data,
  input wire bcac_word_t src_c_data,
  input wire logic src_valid,
  output logic src_ready,
  output bcac_word_t dst_data,
  output bcac_addr_t dst_addr,
  output logic dst_valid,
  input wire logic dst_ready,
  output logic busy
);
  localparam int FW = 16 + 24;
  localparam int CW = $clog2(FIFO_DEPTH + 1);

  if (FIFO_DEPTH < 4) begin : g_chk
    $error("bcac_top: FIFO_DEPTH must be at least 4");
  end

  function automatic logic [11:0] baddr(input logic [9:0] idx);
    baddr = {idx, 2'b00};
  endfunction

  bcac_state_s s;
  bcac_state_s s_nxt;

  ////////////////////////////////////////////////////////////////////////
  // Decoded fields and datapath wires

  logic use_a;
  logic use_b;
  logic use_c;
  logic use_d;
  logic any_src;
  logic descending_addressing;
  logic fill_ex;
  logic fill_in;
  logic [3:0] ash;
  logic [3:0] bsh;
  logic first_col;
  logic last_col;
  logic last_row;
  logic fire;
  bcac_word_t a_raw;
  bcac_word_t a_m;
  bcac_word_t a_sh;
  bcac_word_t b_raw;
  bcac_word_t b_sh;
  bcac_word_t c_raw;
  bcac_word_t mt_word;
  bcac_word_t d_word;
  logic carry_out;
  logic [31:0] a_pair;
  logic [31:0] b_pair;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [FW-1:0] fifo_out_data;
  logic [CW-1:0] fifo_count;
  logic push;
  logic acc;
  logic wr_fire;
  logic rd_fire;
  logic hit_con0;
  logic hit_con1;
  logic hit_fwm;
  logic hit_lwm;
  logic hit_dptr;
  logic hit_size;
  logic hit_stat;
  logic mapped;

  // Field decode of the control words
  assign use_a = s.con0[`BCAC_SOURCE_A_ENABLE_BIT];
  assign use_b = s.con0[`BCAC_SOURCE_B_ENABLE_BIT];
  assign use_c = s.con0[`BCAC_SOURCE_C_ENABLE_BIT];
  assign use_d = s.con0[`BCAC_USED_BIT];
  assign any_src = use_a | use_b | use_c;
  assign ash = s.con0[`BCAC_ASH_HI:`BCAC_ASH_LO];
  assign bsh = s.con1[`BCAC_BSH_HI:`BCAC_BSH_LO];
  assign descending_addressing = s.con1[`BCAC_DESCENDING_ADDRESSING_BIT];
  // Fill only acts in area mode; runs never start in line mode anyway
  assign fill_ex = s.con1[`BCAC_EFE_BIT] & ~s.con1[`BCAC_LINE_BIT];
  assign fill_in = s.con1[`BCAC_IFE_BIT] & ~s.con1[`BCAC_LINE_BIT];

  // Position within the rectangle
  assign first_col = (s.col == 8'h00);
  assign last_col = (s.col == s.width - 8'h01);
  assign last_row = (s.row == s.height - 8'h01);

  // One word per cycle when sources and the buffer both allow it
  assign fire = (s.st == BCAC_RUN) & s.src_ready &
                (src_valid | ~any_src) & (fifo_in_ready | ~use_d);
  assign push = fire & use_d;

  // Disabled sources feed zeros and their data is never sampled
  assign a_raw = use_a ? src_a_data : 16'h0000;
  assign b_raw = use_b ? src_b_data : 16'h0000;
  assign c_raw = use_c ? src_c_data : 16'h0000;

  // Edge masks act before the shift so they trim the fetched words
  assign a_m = a_raw & (first_col ? s.fwm : 16'hFFFF) &
               (last_col ? s.lwm : 16'hFFFF);

  // Shifts pull bits in from the previous word of the same line
  assign a_pair = descending_addressing ? ({a_m, s.prev_a} << ash) :
                         ({s.prev_a, a_m} >> ash);
  assign b_pair = descending_addressing ? ({b_raw, s.prev_b} << bsh) :
                         ({s.prev_b, b_raw} >> bsh);
  assign a_sh = descending_addressing ? a_pair[31:16] : a_pair[15:0];
  assign b_sh = descending_addressing ? b_pair[31:16] : b_pair[15:0];

  bcac_logic_unit u_logic (
    .a_word(a_sh),
    .b_word(b_sh),
    .c_word(c_raw),
    .minterm_select(s.con0[`BCAC_LF_HI:`BCAC_LF_LO]),
    .exclusive_fill_on(fill_ex),
    .inclusive_fill_on(fill_in),
    .carry_in(s.carry),
    .mt_word(mt_word),
    .d_word(d_word),
    .carry_out(carry_out)
  );

  // Result buffer; its occupancy throttles the source side
  bcac_fifo #(
    .WIDTH(FW),
    .DEPTH(FIFO_DEPTH),
    .CW(CW)
  ) u_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .in_data({s.addr, d_word}),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data),
    .count(fifo_count)
  );

  assign fifo_out_ready = ~s.out_valid | dst_ready;

  ////////////////////////////////////////////////////////////////////////
  // APB decode

  assign acc = psel & penable;
  assign wr_fire = acc & s.pready & pwrite;
  assign rd_fire = acc & s.pready & ~pwrite;
  assign hit_con0 = (paddr == baddr(`BCAC_CON0_IDX));
  assign hit_con1 = (paddr == baddr(`BCAC_CON1_IDX));
  assign hit_fwm = (paddr == baddr(`BCAC_FWM_IDX));
  assign hit_lwm = (paddr == baddr(`BCAC_LWM_IDX));
  assign hit_dptr = (paddr == baddr(`BCAC_DPTR_IDX));
  assign hit_size = (paddr == baddr(`BCAC_SIZE_IDX));
  assign hit_stat = (paddr == baddr(`BCAC_STAT_IDX));
  assign mapped = hit_con0 | hit_con1 | hit_fwm | hit_lwm | hit_dptr |
                  hit_size | hit_stat;

  ////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    s_nxt = s;
    // Answer one cycle into the access phase; prdata set up with it
    s_nxt.pready = acc & ~s.pready;
    if (acc & ~s.pready) begin
      s_nxt.pslverr = ~mapped;
      s_nxt.prdata = 32'h00000000;
      if (hit_stat & ~pwrite) begin
        s_nxt.prdata = {16'h0000, 8'(fifo_count), 6'h00,
                        s.line_err, (s.st == BCAC_RUN)};
      end else if (hit_dptr & ~pwrite) begin
        s_nxt.prdata = {8'h00, s.dptr};
      end
    end else begin
      s_nxt.pslverr = 1'b0;
    end
    // Status read clears the refusal flag
    if (rd_fire & hit_stat) begin
      s_nxt.line_err = 1'b0;
    end
    if (wr_fire) begin
      if (hit_con0) begin
        s_nxt.con0 = pwdata[15:0];
      end
      if (hit_con1) begin
        s_nxt.con1 = pwdata[15:0];
      end
      if (hit_fwm) begin
        s_nxt.fwm = pwdata[15:0];
      end
      if (hit_lwm) begin
        s_nxt.lwm = pwdata[15:0];
      end
      if (hit_dptr) begin
        s_nxt.dptr = pwdata[23:0];
      end
      // Size write starts a run; ignored while one is in progress
      if (hit_size & (s.st == BCAC_IDLE)) begin
        if (s.con1[`BCAC_LINE_BIT]) begin
          s_nxt.line_err = 1'b1;
        end else if ((pwdata[`BCAC_SZ_W_HI:`BCAC_SZ_W_LO] != 8'h00) &&
                     (pwdata[`BCAC_SZ_H_HI:`BCAC_SZ_H_LO] != 8'h00)) begin
          s_nxt.st = BCAC_RUN;
          s_nxt.width = pwdata[`BCAC_SZ_W_HI:`BCAC_SZ_W_LO];
          s_nxt.height = pwdata[`BCAC_SZ_H_HI:`BCAC_SZ_H_LO];
          s_nxt.col = 8'h00;
          s_nxt.row = 8'h00;
          s_nxt.addr = s.dptr;
          s_nxt.prev_a = 16'h0000;
          s_nxt.prev_b = 16'h0000;
          s_nxt.carry = s.con1[`BCAC_FCI_BIT];
        end
      end
    end
    // Word step
    if (fire) begin
      s_nxt.prev_a = a_m;
      s_nxt.prev_b = b_raw;
      s_nxt.carry = carry_out;
      s_nxt.col = s.col + 8'h01;
      if (descending_addressing) begin
        s_nxt.addr = s.addr - `BCAC_ADDR_STEP;
      end else begin
        s_nxt.addr = s.addr + `BCAC_ADDR_STEP;
      end
      if (last_col) begin
        // New line: shifter history cleared, carry reloaded
        s_nxt.col = 8'h00;
        s_nxt.row = s.row + 8'h01;
        s_nxt.prev_a = 16'h0000;
        s_nxt.prev_b = 16'h0000;
        s_nxt.carry = s.con1[`BCAC_FCI_BIT];
        if (last_row) begin
          s_nxt.st = BCAC_IDLE;
        end
      end
    end
    // Ready is registered, so leave room for one word in flight
    s_nxt.src_ready = (s_nxt.st == BCAC_RUN) &&
                      (fifo_count < CW'(FIFO_DEPTH - 1));
    // Output stage keeps every destination port on a flip-flop
    if (fifo_out_valid & fifo_out_ready) begin
      s_nxt.out_valid = 1'b1;
      s_nxt.out_data = fifo_out_data[15:0];
      s_nxt.out_addr = fifo_out_data[FW-1:16];
    end else if (dst_ready) begin
      s_nxt.out_valid = 1'b0;
    end
  end

  // State register; masks come up open so a forgotten load is harmless
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.fwm <= `BCAC_MASK_RST;
      s.lwm <= `BCAC_MASK_RST;
      s.con0 <= `BCAC_CON_RST;
      s.con1 <= `BCAC_CON_RST;
    end else begin
      s <= s_nxt;
    end
  end

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign src_ready = s.src_ready;
  assign dst_data = s.out_data;
  assign dst_addr = s.out_addr;
  assign dst_valid = s.out_valid;
  assign busy = (s.st == BCAC_RUN);

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  sequence s_apb_setup;
    psel && !penable;
  endsequence

  sequence s_size_start;
    wr_fire && hit_size && (s.st == BCAC_IDLE);
  endsequence

  a_apb_answer:
  assert property (@(posedge pclk) disable iff (!presetn)
    s_apb_setup ##1 (psel && penable) |-> ##1 pready)
  else $error("APB access not answered in the second access cycle");

  a_first_mask:
  assert property (@(posedge pclk) disable iff (!presetn)
    fire && first_col && !last_col && use_a |->
      a_m == (src_a_data & s.fwm))
  else $error("First word of source A not masked");

  a_last_mask:
  assert property (@(posedge pclk) disable iff (!presetn)
    fire && last_col && !first_col && use_a |->
      a_m == (src_a_data & s.lwm))
  else $error("Last word of source A not masked");

  a_zero_bits:
  assert property (@(posedge pclk) disable iff (!presetn)
    fire && first_col |-> (a_m & ~s.fwm) == 16'h0000)
  else $error("Masked-off source A bit came through");

  a_line_refused:
  assert property (@(posedge pclk) disable iff (!presetn)
    s_size_start and (s.con1[`BCAC_LINE_BIT] == 1'b1) |=>
      (s.st == BCAC_IDLE) && s.line_err ##1 !busy)
  else $error("Run started in line mode");

  a_shift_b:
  assert property (@(posedge pclk) disable iff (!presetn)
    fire && !descending_addressing && first_col |-> b_sh == (b_raw >> bsh))
  else $error("Source B shift wrong at line start");

  a_chan_off:
  assert property (@(posedge pclk) disable iff (!presetn)
    !use_d |=> fifo_count <= $past(fifo_count))
  else $error("Destination disabled but a word was buffered");

  a_minterm_bit:
  assert property (@(posedge pclk) disable iff (!presetn)
    fire && !fill_ex && !fill_in |->
      d_word[0] == s.con0[{a_sh[0], b_sh[0], c_raw[0]}])
  else $error("Result bit does not follow the minterm select");

  a_excl_fill:
  assert property (@(posedge pclk) disable iff (!presetn)
    fire && fill_ex |-> d_word[0] == (s.carry ^ mt_word[0]))
  else $error("Exclusive fill result wrong");

  a_incl_fill:
  assert property (@(posedge pclk) disable iff (!presetn)
    fire && fill_in && !fill_ex |-> d_word[0] == (s.carry | mt_word[0]))
  else $error("Inclusive fill result wrong");

  a_fill_carry:
  assert property (@(posedge pclk) disable iff (!presetn)
    fire && last_col |=> s.carry == s.con1[`BCAC_FCI_BIT])
  else $error("Fill carry not reloaded at line start");

  a_addr_step:
  assert property (@(posedge pclk) disable iff (!presetn)
    fire |=> s.addr == ($past(descending_addressing) ?
      $past(s.addr) - `BCAC_ADDR_STEP : $past(s.addr) + `BCAC_ADDR_STEP))
  else $error("Address did not step in the selected direction");
endmodule

/* File: dv/bcac_mem_model.sv */
`timescale 1ns/100ps

// Memory side: serves source triples and records the first 64 result words
module bcac_mem_model
  import bcac_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic slow,
  input wire logic stall,
  input wire logic clr,
  input wire bcac_word_t a_pat,
  input wire bcac_word_t b_pat,
  input wire bcac_word_t c_pat,
  output bcac_word_t src_a_data,
  output bcac_word_t src_b_data,
  output bcac_word_t src_c_data,
  output logic src_valid,
  input wire logic src_ready,
  input wire bcac_word_t dst_data,
  input wire bcac_addr_t dst_addr,
  input wire logic dst_valid,
  output logic dst_ready
);
  logic [15:0] idx_r;
  logic vld_r;
  logic rdy_r;
  int n_got;
  bcac_word_t got_d [0:63];
  bcac_addr_t got_a [0:63];
  bcac_word_t wa;
  bcac_word_t wb;
  bcac_word_t wc;

  // Word i of a stream is the pattern with a per-index twist
  assign wa = a_pat ^ 16'(idx_r * 16'h1111);
  assign wb = b_pat ^ 16'(idx_r * 16'h1111);
  assign wc = c_pat ^ 16'(idx_r * 16'h1111);
  // Idle lines show the inverse so stale data is never mistaken
  assign src_a_data = vld_r ? wa : ~wa;
  assign src_b_data = vld_r ? wb : ~wb;
  assign src_c_data = vld_r ? wc : ~wc;
  assign src_valid = vld_r;
  assign dst_ready = rdy_r & ~stall;

  // Slow mode gaps the source and toggles the sink ready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idx_r <= 16'h0000;
      vld_r <= 1'b0;
      rdy_r <= 1'b0;
      n_got <= 0;
    end else begin
      rdy_r <= slow ? ~rdy_r : 1'b1;
      if (vld_r && src_ready) begin
        vld_r <= !slow;
      end else begin
        vld_r <= 1'b1;
      end
      if (clr) begin
        idx_r <= 16'h0000;
        n_got <= 0;
      end else begin
        if (vld_r && src_ready) idx_r <= idx_r + 16'h0001;
        if (dst_valid && dst_ready && n_got < 64) begin
          got_d[n_got] <= dst_data;
          got_a[n_got] <= dst_addr;
          n_got <= n_got + 1;
        end
      end
    end
  end
endmodule

/* File: dv/bcac_top_tb.sv */
`timescale 1ns/100ps

module bcac_top_tb
  import bcac_pkg::*;
;
  localparam logic [11:0] A_CON0 = 12'h100;
  localparam logic [11:0] A_CON1 = 12'h108;
  localparam logic [11:0] A_FWM = 12'h110;
  localparam logic [11:0] A_LWM = 12'h118;
  localparam logic [11:0] A_DPTR = 12'h120;
  localparam logic [11:0] A_SIZE = 12'h128;
  localparam logic [11:0] A_STAT = 12'h130;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  bcac_word_t src_a_data;
  bcac_word_t src_b_data;
  bcac_word_t src_c_data;
  bcac_word_t dst_data;
  bcac_addr_t dst_addr;
  logic src_valid;
  logic src_ready;
  logic dst_valid;
  logic dst_ready;
  logic busy;
  logic slow = 1'b0;
  logic stall = 1'b0;
  logic clr = 1'b0;
  bcac_word_t a_pat = 16'h0000;
  bcac_word_t b_pat = 16'h0000;
  bcac_word_t c_pat = 16'h0000;
  int miscompares = 0;
  int tests_run = 0;
  bcac_word_t exp_d [0:63];
  logic [31:0] rd;
  logic er;

  bcac_top #(.FIFO_DEPTH(32)) bcac_top_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .src_a_data(src_a_data), .src_b_data(src_b_data),
    .src_c_data(src_c_data), .src_valid(src_valid), .src_ready(src_ready),
    .dst_data(dst_data), .dst_addr(dst_addr), .dst_valid(dst_valid),
    .dst_ready(dst_ready), .busy(busy));
  bcac_mem_model bcac_mem_model_i (.pclk(pclk), .presetn(presetn),
    .slow(slow), .stall(stall), .clr(clr), .a_pat(a_pat), .b_pat(b_pat),
    .c_pat(c_pat), .src_a_data(src_a_data), .src_b_data(src_b_data),
    .src_c_data(src_c_data), .src_valid(src_valid), .src_ready(src_ready),
    .dst_data(dst_data), .dst_addr(dst_addr), .dst_valid(dst_valid),
    .dst_ready(dst_ready));

  // 100 ns clock
  initial begin
    forever #50 pclk = ~pclk;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Ready is sampled at the rising edge, before that edge's updates land
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic bcac_word_t sw(bcac_word_t p, int i);
    return p ^ 16'(i * 16'h1111);
  endfunction

  task automatic start(input bcac_word_t c0, c1, fm, lm,
                       input bcac_addr_t dp, input logic [7:0] h, w);
    @(posedge pclk);
    clr <= 1'b1;
    @(posedge pclk);
    clr <= 1'b0;
    apb(1'b1, A_CON0, {16'h0, c0});
    apb(1'b1, A_CON1, {16'h0, c1});
    apb(1'b1, A_FWM, {16'h0, fm});
    apb(1'b1, A_LWM, {16'h0, lm});
    apb(1'b1, A_DPTR, {8'h0, dp});
    apb(1'b1, A_SIZE, {16'h0, h, w});
  endtask

  // Bounded by the watchdog; a few spare cycles expose surplus words
  task automatic finish(input int n);
    @(negedge pclk);
    chk(busy, 1);
    while (busy !== 1'b0 || bcac_mem_model_i.n_got < n) @(negedge pclk);
    repeat (3) @(negedge pclk);
  endtask

  task automatic words(input int n, input bcac_addr_t dp, input logic dn);
    chk(32'(bcac_mem_model_i.n_got), 32'(n));
    for (int k = 0; k < n; k++) begin
      chk(bcac_mem_model_i.got_d[k], exp_d[k]);
      chk(bcac_mem_model_i.got_a[k],
          dn ? dp - 24'(2 * k) : dp + 24'(2 * k));
    end
  endtask

  task automatic t_regs();
    apb(1'b0, A_CON0, 32'h0);
    chk(rd, 0);
    chk(er, 0);
    apb(1'b1, A_DPTR, 32'h00123456);
    apb(1'b0, A_DPTR, 32'h0);
    chk(rd, 32'h00123456);
    apb(1'b0, 12'h004, 32'h0);
    chk({er, rd[30:0]}, 32'h80000000);
    apb(1'b0, A_STAT, 32'h0);
    chk(rd[1:0], 0);
    $display("regs done");
  endtask

  task automatic t_mask();
    a_pat <= 16'hFFFF;
    for (int k = 0; k < 6; k++) begin
      exp_d[k] = sw(16'hFFFF, k);
      if (k % 3 == 0) exp_d[k] &= 16'h0FF0;
      if (k % 3 == 2) exp_d[k] &= 16'hF00F;
    end
    start(16'h09F0, 16'h0000, 16'h0FF0, 16'hF00F, 24'h001000, 8'h02, 8'h03);
    finish(6);
    words(6, 24'h001000, 1'b0);
    $display("mask done");
  endtask

  function automatic bcac_word_t lfe(logic [7:0] lf, bcac_word_t a, b, c);
    bcac_word_t r;
    for (int i = 0; i < 16; i++) r[i] = lf[{a[i], b[i], c[i]}];
    return r;
  endfunction

  task automatic t_logic();
    a_pat <= 16'hFF00;
    b_pat <= 16'hF0F0;
    c_pat <= 16'hCCCC;
    for (int k = 0; k < 9; k++) begin
      // Last pass drops B and C, which must then read as zero
      logic [7:0] lf;
      lf = (k < 8) ? 8'(1 << k) : 8'h01;
      exp_d[0] = (k < 8) ? lfe(lf, 16'hFF00, 16'hF0F0, 16'hCCCC) :
                 lfe(lf, 16'hFF00, 16'h0000, 16'h0000);
      start((k < 8) ? {8'h0F, lf} : {8'h09, lf}, 16'h0000, 16'hFFFF,
            16'hFFFF, 24'h000200, 8'h01, 8'h01);
      finish(1);
      words(1, 24'h000200, 1'b0);
    end
    start(16'h0EF0, 16'h0000, 16'hFFFF, 16'hFFFF, 24'h0, 8'h01, 8'h02);
    finish(0);
    words(0, 24'h0, 1'b0);
    $display("logic done");
  endtask

  task automatic t_shift();
    a_pat <= 16'h1234;
    b_pat <= 16'hA5C3;
    for (int s = 0; s < 2; s++) begin
      for (int k = 0; k < 4; k++) begin
        bcac_word_t p;
        p = s ? 16'hA5C3 : 16'h1234;
        exp_d[k] = (k % 2 == 0) ? sw(p, k) >> (s ? 8 : 4) :
                   16'({sw(p, k - 1), sw(p, k)} >> (s ? 8 : 4));
      end
      start(s ? 16'h05CC : 16'h49F0, s ? 16'h8000 : 16'h0000, 16'hFFFF,
            16'hFFFF, 24'h000400, 8'h02, 8'h02);
      finish(4);
      words(4, 24'h000400, 1'b0);
    end
    $display("shift done");
  endtask

  function automatic bcac_word_t fil(bcac_word_t w, logic ci, logic ex);
    bcac_word_t r;
    logic c;
    c = ci;
    for (int i = 0; i < 16; i++) begin
      r[i] = ex ? c ^ w[i] : w[i] | c;
      c = c ^ w[i];
    end
    return r;
  endfunction

  task automatic t_fill();
    logic [3:0] mode [4] = '{4'h2, 4'h3, 4'h1, 4'h0};
    a_pat <= 16'h0410;
    for (int m = 0; m < 4; m++) begin
      for (int k = 0; k < 2; k++)
        exp_d[k] = fil(sw(16'h0410, k), mode[m][0], mode[m][1]);
      // Masks stay all ones for fill
      start(16'h09F0, {11'h0, mode[m][1], ~mode[m][1], mode[m][0], 2'b00},
            16'hFFFF, 16'hFFFF, 24'h000600, 8'h02, 8'h01);
      finish(2);
      words(2, 24'h000600, 1'b0);
    end
    $display("fill done");
  endtask

  task automatic t_descending_addressing();
    a_pat <= 16'h5A5A;
    for (int k = 0; k < 3; k++) exp_d[k] = sw(16'h5A5A, k);
    start(16'h09F0, 16'h0002, 16'hFFFF, 16'hFFFF, 24'h002000, 8'h01, 8'h03);
    finish(3);
    words(3, 24'h002000, 1'b1);
    $display("descending_addressing done");
  endtask

  task automatic t_line();
    apb(1'b1, A_CON1, 32'h1);
    apb(1'b1, A_SIZE, 32'h0101);
    @(negedge pclk);
    chk(busy, 0);
    apb(1'b0, A_STAT, 32'h0);
    chk(rd[1:0], 2'b10);
    apb(1'b0, A_STAT, 32'h0);
    chk(rd[1:0], 2'b00);
    $display("line done");
  endtask

  // Sink stalls until the buffer refuses, then drains slowly
  task automatic t_fifo();
    a_pat <= 16'h0F0F;
    stall <= 1'b1;
    for (int k = 0; k < 40; k++) exp_d[k] = sw(16'h0F0F, k);
    start(16'h09F0, 16'h0000, 16'hFFFF, 16'hFFFF, 24'h003000, 8'h01, 8'h28);
    repeat (60) @(negedge pclk);
    chk(src_ready, 0);
    apb(1'b0, A_STAT, 32'h0);
    chk(32'(rd[15:8] >= 8'd31), 1);
    stall <= 1'b0;
    slow <= 1'b1;
    while (busy !== 1'b0 || bcac_mem_model_i.n_got < 40) @(negedge pclk);
    words(40, 24'h003000, 1'b0);
    slow <= 1'b0;
    $display("fifo done");
  endtask

  initial begin
    #(100 * 60000);
    miscompares++;
    stop_test();
  end

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_mask();
    t_logic();
    t_shift();
    t_fill();
    t_descending_addressing();
    t_line();
    t_fifo();
    stop_test();
  end
endmodule
